// [dram_init_pkg.sv]
// Purpose: constants for the DDR3 device-side reset, init and mode register block
// Assumes: one 200 MHz clock; command pins sampled on the rising edge
// Notes: the init wait cycle count is derived from its time at the clock rate; DLL lock and ZQ counts are given in cycles
package dram_init_pkg;
  localparam int CLK_MHZ = 200;
  localparam int INIT_WAIT_US = 500;
  localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
  localparam int DLLK_CYC = 512;
  localparam int ZQINIT_CYC = 512;
  localparam int CNT_W = 17;
  localparam int LCNT_W = 10;
  localparam int ADDR_W = 15;
  localparam int BA_W = 3;
  localparam int NUM_MR = 4;
  localparam int DLL_RST_BIT = 8;
  localparam int ZQ_LONG_BIT = 10;
  localparam logic [ADDR_W-1:0] MR_RESET_VAL = 15'h0000;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_INTINIT = 3'h1,
    ST_WAIT_CKE = 3'h3,
    ST_CONFIG = 3'h2,
    ST_READY = 3'h6
  } dev_state_t;
endpackage

// [dram_init_dev.sv]
// Purpose: device-side power-up/reset sequencing and mode register storage
// Assumes: RST_N is the device reset pin, other pins synchronous to CLK
// Notes: no memory array here; besides the mode registers only the sequencing state, status flags and counters are stored
`timescale 1ns/1ps
`default_nettype none
module dram_init_dev #(
  parameter int INIT_CYCLES = dram_init_pkg::INIT_WAIT_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [dram_init_pkg::BA_W-1:0] BA,
  input wire logic [dram_init_pkg::ADDR_W-1:0] ADDR,
  input wire logic ODT,
  output logic TERM_ON,
  output logic INT_INIT_DONE,
  output logic CKE_EARLY,
  output logic [dram_init_pkg::NUM_MR-1:0] MR_VALID,
  output logic [dram_init_pkg::ADDR_W-1:0] MR0,
  output logic [dram_init_pkg::ADDR_W-1:0] MR1,
  output logic [dram_init_pkg::ADDR_W-1:0] MR2,
  output logic [dram_init_pkg::ADDR_W-1:0] MR3,
  output logic DLL_LOCKED,
  output logic ZQ_DONE,
  output logic INIT_DONE
);
  import dram_init_pkg::*;

  typedef struct packed {
    dev_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [LCNT_W-1:0] dll_cnt;
    logic [LCNT_W-1:0] zq_cnt;
    logic dll_lock;
    logic zq_ok;
    logic int_done;
    logic cke_early;
    logic term;
    logic done;
    logic [NUM_MR-1:0] mr_ok;
    logic [NUM_MR-1:0][ADDR_W-1:0] mr;
  } dev_regs_t;

  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
  localparam logic [LCNT_W-1:0] DLLK_LAST = LCNT_W'(DLLK_CYC - 1);
  localparam logic [LCNT_W-1:0] ZQ_LAST = LCNT_W'(ZQINIT_CYC - 1);

  logic rst_meta_q;
  logic rst_n_q;
  dev_regs_t r_q;
  dev_regs_t r_d;
  logic cmd_mrs;
  logic cmd_zqcl;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // command decode, only with CKE high
  assign cmd_mrs = CKE && !CS_N && !RAS_N && !CAS_N && !WE_N;
  assign cmd_zqcl = CKE && !CS_N && RAS_N && CAS_N && !WE_N && ADDR[ZQ_LONG_BIT];

  always_comb begin
    r_d = r_q;
    case (r_q.st)
      ST_RESET: begin
        r_d.cnt = '0;
        r_d.st = ST_INTINIT;
      end
      // internal init, no clock needed by controller
      ST_INTINIT: begin
        if (CKE) begin
          r_d.cke_early = 1'b1;
        end
        if (r_q.cnt == INIT_LAST) begin
          r_d.int_done = 1'b1;
          r_d.st = ST_WAIT_CKE;
        end else begin
          r_d.cnt = r_q.cnt + CNT_W'(1);
        end
      end
      ST_WAIT_CKE: begin
        if (CKE) begin
          r_d.st = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (r_q.dll_lock && r_q.zq_ok && (&r_q.mr_ok)) begin
          r_d.done = 1'b1;
          r_d.st = ST_READY;
        end
      end
      ST_READY: begin
        r_d.done = 1'b1;
      end
      default: begin
        r_d.st = ST_RESET;
      end
    endcase

    // termination stays off until CKE registered
    r_d.term = (r_q.st == ST_CONFIG || r_q.st == ST_READY) && ODT;

    // DLL lock count runs while not locked
    if (!r_q.dll_lock && r_q.dll_cnt != '0) begin
      r_d.dll_cnt = r_q.dll_cnt - LCNT_W'(1);
      if (r_q.dll_cnt == LCNT_W'(1)) begin
        r_d.dll_lock = 1'b1;
      end
    end
    if (!r_q.zq_ok && r_q.zq_cnt != '0) begin
      r_d.zq_cnt = r_q.zq_cnt - LCNT_W'(1);
      if (r_q.zq_cnt == LCNT_W'(1)) begin
        r_d.zq_ok = 1'b1;
      end
    end

    // DLL reset bit self-clears, starts lock wait
    if (r_q.mr[0][DLL_RST_BIT]) begin
      r_d.mr[0][DLL_RST_BIT] = 1'b0;
      r_d.dll_lock = 1'b0;
      r_d.dll_cnt = DLLK_LAST + LCNT_W'(1);
    end

    if (r_q.st == ST_CONFIG || r_q.st == ST_READY) begin
      // MRS touches only the selected mode register and its valid bit
      if (cmd_mrs && BA[2] == 1'b0) begin
        r_d.mr[BA[1:0]] = ADDR;
        r_d.mr_ok[BA[1:0]] = 1'b1;
      end
      if (cmd_zqcl) begin
        r_d.zq_ok = 1'b0;
        r_d.zq_cnt = ZQ_LAST + LCNT_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      r_q.st <= ST_RESET;
      r_q.cnt <= '0;
      r_q.dll_cnt <= '0;
      r_q.zq_cnt <= '0;
      r_q.dll_lock <= 1'b0;
      r_q.zq_ok <= 1'b0;
      r_q.int_done <= 1'b0;
      r_q.cke_early <= 1'b0;
      r_q.term <= 1'b0;
      r_q.done <= 1'b0;
      r_q.mr_ok <= '0;
      r_q.mr <= {NUM_MR{MR_RESET_VAL}};
    end else begin
      r_q <= r_d;
    end
  end

  assign TERM_ON = r_q.term;
  assign INT_INIT_DONE = r_q.int_done;
  assign CKE_EARLY = r_q.cke_early;
  assign MR_VALID = r_q.mr_ok;
  assign MR0 = r_q.mr[0];
  assign MR1 = r_q.mr[1];
  assign MR2 = r_q.mr[2];
  assign MR3 = r_q.mr[3];
  assign DLL_LOCKED = r_q.dll_lock;
  assign ZQ_DONE = r_q.zq_ok;
  assign INIT_DONE = r_q.done;

  // helper: cycles since release, saturating
  logic [CNT_W-1:0] since_rel_q;
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      since_rel_q <= '0;
    end else if (since_rel_q != '1) begin
      since_rel_q <= since_rel_q + CNT_W'(1);
    end
  end

  AST_INIT_WAIT: assert property (
    @(posedge CLK) disable iff (!rst_n_q)
    $rose(r_q.int_done) |-> since_rel_q == CNT_W'(INIT_CYCLES + 1))
    else $error("internal init not exactly the init wait");

  AST_TERM_OFF: assert property (
    @(posedge CLK) disable iff (!rst_n_q)
    (r_q.st != ST_CONFIG && r_q.st != ST_READY) |=> !TERM_ON)
    else $error("termination on before CKE registered");

  AST_MRS_STORE: assert property (
    @(posedge CLK) disable iff (!rst_n_q)
    (cmd_mrs && BA == 3'h2 && (r_q.st == ST_CONFIG || r_q.st == ST_READY)) |=>
    MR2 == $past(ADDR) && MR_VALID[2])
    else $error("mode register 2 write lost");

  AST_MRS_ONLY_SEL: assert property (
    @(posedge CLK) disable iff (!rst_n_q)
    (cmd_mrs && BA[1:0] != 2'h3) |=> $stable(MR3))
    else $error("unselected mode register changed");

  // helper: cycles since the last dll reset request, saturating
  logic [LCNT_W-1:0] lock_age_q;
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_age_q <= '0;
    end else if (r_q.mr[0][DLL_RST_BIT]) begin
      lock_age_q <= '0;
    end else if (lock_age_q != '1) begin
      lock_age_q <= lock_age_q + LCNT_W'(1);
    end
  end

  AST_DLL_SELF_CLR: assert property (
    @(posedge CLK) disable iff (!rst_n_q)
    MR0[DLL_RST_BIT] |=> !MR0[DLL_RST_BIT] && !DLL_LOCKED)
    else $error("dll reset bit not cleared");

  // lock without a request leaves the age saturated, so this fires too
  AST_DLL_LOCK_TIME: assert property (
    @(posedge CLK) disable iff (!rst_n_q)
    $rose(DLL_LOCKED) |-> lock_age_q == LCNT_W'(DLLK_CYC))
    else $error("dll lock time wrong");

  AST_RESET_CLEAN: assert property (
    @(posedge CLK)
    !rst_n_q |-> !INIT_DONE && !TERM_ON && MR_VALID == '0)
    else $error("outputs not cleared during reset");

  COV_READY: cover property (@(posedge CLK) disable iff (!rst_n_q) $rose(INIT_DONE));
  COV_ZQ: cover property (@(posedge CLK) disable iff (!rst_n_q) $rose(ZQ_DONE));
  COV_EARLY: cover property (@(posedge CLK) disable iff (!rst_n_q) $rose(CKE_EARLY));
endmodule // dram_init_dev
`default_nettype wire

// [ctrl_model.sv]
// Purpose: controller-side driver of reset, CKE, ODT and command pins
// Assumes: pins change at the rising edge by non-blocking assignment
// Notes: released bank and address lines show the inverse of their last value; cmd_n returns to 4'hf
`timescale 1ns/1ps
`default_nettype none
module ctrl_model import dram_init_pkg::*; #(
  parameter int MRD_CYC = 4
) (
  input wire logic clk,
  output logic rst_n,
  output logic cke,
  output logic odt,
  output logic [3:0] cmd_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr
);
  initial begin
    rst_n = 1'b0;
    cke = 1'b0;
    odt = 1'b1;
    cmd_n = 4'hf;
    ba = 3'h0;
    addr = 15'h0000;
  end
  task automatic rst_lo();
    @(posedge clk);
    rst_n <= 1'b0;
    cke <= 1'b0;
  endtask
  task automatic rst_hi();
    @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic cke_set(input logic v);
    @(posedge clk);
    cke <= v;
  endtask
  task automatic odt_set(input logic v);
    @(posedge clk);
    odt <= v;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
    @(posedge clk);
    cmd_n <= c;
    ba <= b;
    addr <= a;
    @(posedge clk);
    cmd_n <= 4'hf;
    ba <= ~b;
    addr <= ~a;
    repeat (MRD_CYC) @(posedge clk);
  endtask
endmodule // ctrl_model
`default_nettype wire

// [dram_init_and_mode_reg_setup_tb.sv]
// Purpose: self-checking bench for the device-side init block
// Assumes: internal init wait shortened to INIT_N cycles
// Notes: lock and calibration waits stay at 512 cycles
`timescale 1ns/1ps
`default_nettype none
module dram_init_and_mode_reg_setup_tb;
  import dram_init_pkg::*;
  localparam int INIT_N = 20;
  logic CLK = 1'b0;
  wire logic RST_N, CKE, ODT, TERM_ON, INT_INIT_DONE, CKE_EARLY, DLL_LOCKED, ZQ_DONE, INIT_DONE;
  wire logic [3:0] C, MR_VALID;
  wire logic [BA_W-1:0] BA;
  wire logic [ADDR_W-1:0] ADDR, MR0, MR1, MR2, MR3;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #2.5 CLK = ~CLK;
  ctrl_model m (.clk(CLK), .rst_n(RST_N), .cke(CKE), .odt(ODT), .cmd_n(C), .ba(BA), .addr(ADDR));
  dram_init_dev #(.INIT_CYCLES(INIT_N)) u_dut (.CLK, .RST_N, .CKE, .CS_N(C[3]), .RAS_N(C[2]),
    .CAS_N(C[1]), .WE_N(C[0]), .BA, .ADDR, .ODT, .TERM_ON, .INT_INIT_DONE, .CKE_EARLY,
    .MR_VALID, .MR0, .MR1, .MR2, .MR3, .DLL_LOCKED, .ZQ_DONE, .INIT_DONE);
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // reset hold shortened for sim; 20 cycles still meets 100ns
  task automatic t_reset();
    m.rst_lo();
    tick(19);
    chk_bit("term_in_reset", 1'h0, TERM_ON);
    chk("valid_in_reset", 15'h0000, 15'(MR_VALID));
    m.rst_hi();
    tick(10);
    chk_bit("init_early", 1'h0, INT_INIT_DONE);
  endtask
  task automatic t_cfg();
    int n;
    n = 0;
    while (n < 100 && INT_INIT_DONE !== 1'h1) begin
      tick(1);
      n++;
    end
    // two sync flops and state entry add three edges
    chk("init_wait", 15'(INIT_N + 3 - 10), 15'(n));
    chk_bit("term_before_cke", 1'h0, TERM_ON);
    m.odt_set(1'h0);
    m.cke_set(1'h1);
    tick(5);
    chk_bit("term_odt_low", 1'h0, TERM_ON);
    m.cmd(4'h0, 3'h2, 15'h0018);
    m.cmd(4'h0, 3'h3, 15'h0004);
    m.cmd(4'h0, 3'h1, 15'h0046);
    m.cmd(4'h0, 3'h0, 15'h0120);
    tick(1);
    chk("mr2", 15'h0018, MR2);
    chk("mr3", 15'h0004, MR3);
    chk("mr1", 15'h0046, MR1);
    chk("mr0", 15'h0020, MR0);
    chk("valid", 15'h000f, 15'(MR_VALID));
    chk_bit("dll_relock", 1'h0, DLL_LOCKED);
    m.cmd(4'h6, 3'h0, 15'h0400);
    tick(495);
    chk_bit("done_early", 1'h0, INIT_DONE);
    chk_bit("dll_lock_early", 1'h0, DLL_LOCKED);
    n = 0;
    while (n < 100 && INIT_DONE !== 1'h1) begin
      tick(1);
      n++;
    end
    // zq taken 4 edges before cmd returns, done one edge after zq
    chk("done_wait", 15'(ZQINIT_CYC + 1 - 4 - 495), 15'(n));
    chk_bit("done", 1'h1, INIT_DONE);
    chk_bit("zq", 1'h1, ZQ_DONE);
    chk_bit("dll_locked", 1'h1, DLL_LOCKED);
    chk_bit("early_cke", 1'h0, CKE_EARLY);
    m.odt_set(1'h1);
    tick(2);
    chk_bit("term_on", 1'h1, TERM_ON);
  endtask
  task automatic t_warm();
    m.odt_set(1'h0);
    m.cmd(4'h0, 3'h1, 15'h0044);
    chk("mr1_rewrite", 15'h0044, MR1);
    t_reset();
    chk("mr1_cleared", 15'h0000, MR1);
    chk_bit("done_cleared", 1'h0, INIT_DONE);
    t_cfg();
  endtask
  // cke raised inside the internal init wait; mrs there is dropped
  task automatic t_early();
    t_reset();
    m.cke_set(1'h1);
    tick(2);
    chk_bit("early_flag", 1'h1, CKE_EARLY);
    chk_bit("early_no_init", 1'h0, INT_INIT_DONE);
    chk_bit("term_early", 1'h0, TERM_ON);
    m.cmd(4'h0, 3'h2, 15'h0018);
    chk("early_mrs_dropped", 15'h0000, 15'(MR_VALID));
    m.cke_set(1'h0);
  endtask
  // run is about 1240 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    t_reset();
    t_cfg();
    t_warm();
    t_early();
    summarize();
  end
endmodule // dram_init_and_mode_reg_setup_tb
`default_nettype wire
